// ===== hw/fifo_ctl_pkg.sv
// fifo control package: register map, field layout, reset values, levels
// assumes an 8-bit register port with index-style offsets
package fifo_ctl_pkg;

    // ------------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_DATA     = 8'h00;  // write: tx push, read: rx pop
    localparam logic [7:0] OFF_CONTROL  = 8'h02;  // fifo_control
    localparam logic [7:0] OFF_TX_LEVEL = 8'h08;  // tx occupancy
    localparam logic [7:0] OFF_RX_LEVEL = 8'h09;  // rx occupancy
    localparam logic [7:0] OFF_STATUS   = 8'h0a;  // event status, read only
    localparam logic [7:0] OFF_CLEAR    = 8'h0b;  // write 1 to clear, write only
    localparam logic [7:0] OFF_ENABLE   = 8'h0c;  // interrupt enables

    // ------------------------------------------------------------------
    // fifo_control fields
    // ------------------------------------------------------------------
    localparam int BIT_FIFO_EN  = 0;
    localparam int BIT_RX_CLEAR = 1;
    localparam int BIT_TX_CLEAR = 2;
    localparam int BIT_DMA_MODE = 3;
    localparam int BIT_DEEP     = 5;
    localparam int BIT_TRIG_LO  = 6;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // ------------------------------------------------------------------
    // status / enable / clear layout
    // ------------------------------------------------------------------
    localparam int ST_RX_LEVEL   = 0;  // live: rx at or above trigger, or any rx data with fifos off
    localparam int ST_TX_LOW     = 1;  // live: tx below trigger, mode 1
    localparam int ST_RX_HIT     = 2;  // sticky: rx count reached trigger
    localparam int ST_RX_TIMEOUT = 3;  // sticky: receive time-out
    localparam int ST_RX_OVERRUN = 4;  // sticky: push into a full rx fifo
    localparam int ST_W          = 5;
    localparam logic [4:0] STICKY_MASK = 5'h1c;

    // ------------------------------------------------------------------
    // depths and trigger levels
    // ------------------------------------------------------------------
    localparam int CNT_W = 7;
    localparam int PTR_W = 6;
    localparam int MEM_DEPTH = 64;
    localparam logic [6:0] CAP_SINGLE = 7'h01;
    localparam logic [6:0] CAP_SHALLOW = 7'h10;
    localparam logic [6:0] CAP_DEEP = 7'h40;
    localparam logic [6:0] TRIG16_0 = 7'h01;
    localparam logic [6:0] TRIG16_1 = 7'h04;
    localparam logic [6:0] TRIG16_2 = 7'h08;
    localparam logic [6:0] TRIG16_3 = 7'h0e;
    localparam logic [6:0] TRIG64_0 = 7'h01;
    localparam logic [6:0] TRIG64_1 = 7'h10;
    localparam logic [6:0] TRIG64_2 = 7'h20;
    localparam logic [6:0] TRIG64_3 = 7'h38;

endpackage

// ===== hw/uart_fifo_control.sv
// uart fifo control: tx/rx character fifos, clears, trigger, dma request pins
// assumes a synchronous register port and a shifter that pops tx / pushes rx
//
// Summary of operation
// - In dma mode 0 or with fifos off, tx request is low while no tx character is held.
// - In dma mode 0 or with fifos off, rx request is low while any rx character is held.
// - In dma mode 1, tx request goes high when the tx fifo is full and low once empty.
// - In dma mode 1, rx request goes low at the trigger or a time-out, high once empty.
// - In dma mode 1, rx request stays low while the rx level is above the trigger.
// - In dma mode 1, the tx interrupt condition stands while tx level is below trigger.
// - The rx interrupt fires when rx count equals the trigger; filling goes on to full.
// - The trigger field picks 1/4/8/14 in 16-deep mode and 1/16/32/56 in 64-deep mode.
// - Control bit 5 picks 16-deep (0) or 64-deep (1) operation for both directions.
// - Writing 1 to control bit 2 empties the tx fifo; the bit reads back as 0.
// - Writing 1 to control bit 1 empties the rx fifo; the bit reads back as 0.
// - Control bit 0 enables both fifos; cleared, each side holds one character.
// - Control bit 3 picks dma mode 0 (clear) or mode 1 (set).
// - After reset every control field is 0: fifos off, mode 0, 16-deep.
// - The rx data interrupt is withdrawn once the rx level falls below the trigger.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

module uart_fifo_control #(
    parameter int DATA_W = 8                            // character width
) (
    input  wire logic                 ref_clk,          // 10 MHz system clock
    input  wire logic                 rst_n,            // synchronous reset, active low
    input  wire logic [7:0]           reg_addr,         // register index
    input  wire logic [7:0]           reg_wdata,        // write data
    input  wire logic                 reg_write,        // write strobe
    input  wire logic                 reg_read,         // read strobe
    output logic      [7:0]           reg_rdata,        // read data, cycle after strobe
    output logic      [DATA_W-1:0]    tx_data,          // head of tx fifo
    output logic                      tx_valid,         // tx character available
    input  wire logic                 tx_pop,           // shifter takes head
    input  wire logic [DATA_W-1:0]    rx_data,          // assembled character
    input  wire logic                 rx_push,          // shifter delivers character
    input  wire logic                 rx_timeout,       // receive time-out pulse
    output logic                      tx_dma_request_n, // tx ready pin, active low
    output logic                      rx_dma_request_n, // rx ready pin, active low
    output logic                      irq               // level interrupt
);
    import fifo_ctl_pkg::*;

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if (DATA_W < 5 || DATA_W > 8) begin : g_bad_width
        $error("DATA_W must lie between 5 and 8");
    end

    // trigger decode, shared by both directions
    function automatic logic [CNT_W-1:0] trig_of(input logic [1:0] f, input logic deep);
        logic [CNT_W-1:0] t;
        t = TRIG16_0;
        unique case (f)
            2'b00: t = deep ? TRIG64_0 : TRIG16_0;
            2'b01: t = deep ? TRIG64_1 : TRIG16_1;
            2'b10: t = deep ? TRIG64_2 : TRIG16_2;
            2'b11: t = deep ? TRIG64_3 : TRIG16_3;
        endcase
        return t;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic              fifo_en_reg;
    logic              dma_mode_reg;
    logic              deep_reg;
    logic [1:0]        rx_trigger_field_reg;
    logic [DATA_W-1:0] tx_mem [MEM_DEPTH];
    logic [DATA_W-1:0] rx_mem [MEM_DEPTH];
    logic [PTR_W-1:0]  tx_wr_ptr_reg;
    logic [PTR_W-1:0]  tx_rd_ptr_reg;
    logic [PTR_W-1:0]  rx_wr_ptr_reg;
    logic [PTR_W-1:0]  rx_rd_ptr_reg;
    logic [CNT_W-1:0]  tx_count_reg;
    logic [CNT_W-1:0]  rx_count_reg;
    logic [ST_W-1:0]   sticky_reg;
    logic [ST_W-1:0]   enable_reg;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic              ctl_wr;
    logic              tx_fifo_clear;
    logic              rx_fifo_clear;
    logic              fifo_en_next;
    logic              dma_mode_next;
    logic              deep_next;
    logic [1:0]        trig_field_next;
    logic              dma1_next;
    logic [CNT_W-1:0]  cap_next;
    logic [CNT_W-1:0]  trig_next;
    logic              tx_push;
    logic              tx_take;
    logic              rx_take;
    logic              rx_keep;
    logic              rx_overrun;
    logic [CNT_W-1:0]  tx_count_next;
    logic [CNT_W-1:0]  rx_count_next;
    logic [PTR_W-1:0]  tx_rd_ptr_next;
    logic [ST_W-1:0]   live_next;
    logic [ST_W-1:0]   sticky_next;

    // control write and its self-clearing strobes
    assign ctl_wr          = reg_write && reg_addr == OFF_CONTROL;
    assign tx_fifo_clear   = ctl_wr && reg_wdata[BIT_TX_CLEAR];
    assign rx_fifo_clear   = ctl_wr && reg_wdata[BIT_RX_CLEAR];
    assign fifo_en_next    = ctl_wr ? reg_wdata[BIT_FIFO_EN] : fifo_en_reg;
    assign dma_mode_next   = ctl_wr ? reg_wdata[BIT_DMA_MODE] : dma_mode_reg;
    assign deep_next       = ctl_wr ? reg_wdata[BIT_DEEP] : deep_reg;
    assign trig_field_next = ctl_wr ? reg_wdata[BIT_TRIG_LO+:2] : rx_trigger_field_reg;
    assign dma1_next       = fifo_en_next && dma_mode_next;

    // capacity: one holding register, 16 or 64 entries
    assign cap_next  = !fifo_en_next ? CAP_SINGLE :
                       (deep_next ? CAP_DEEP : CAP_SHALLOW);
    assign trig_next = trig_of(trig_field_next, deep_next);

    // transfers, judged against the current fill
    assign tx_push    = reg_write && reg_addr == OFF_DATA && tx_count_reg < cap_next;
    assign tx_take    = tx_pop && tx_count_reg != '0;
    assign rx_take    = reg_read && reg_addr == OFF_DATA && rx_count_reg != '0;
    assign rx_keep    = rx_push && rx_count_reg < cap_next;
    assign rx_overrun = rx_push && !rx_keep;

    // next fill levels; a clear empties counters, shifters untouched
    always_comb begin
        tx_count_next = tx_count_reg + CNT_W'(tx_push) - CNT_W'(tx_take);
        rx_count_next = rx_count_reg + CNT_W'(rx_keep) - CNT_W'(rx_take);
        if (tx_fifo_clear) begin
            tx_count_next = '0;
        end
        if (rx_fifo_clear) begin
            rx_count_next = '0;
        end
    end

    assign tx_rd_ptr_next = tx_fifo_clear ? '0 : tx_rd_ptr_reg + PTR_W'(tx_take);

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    // fields clear at reset; clear bits never stored
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fifo_en_reg          <= CONTROL_RESET[BIT_FIFO_EN];
            dma_mode_reg         <= CONTROL_RESET[BIT_DMA_MODE];
            deep_reg             <= CONTROL_RESET[BIT_DEEP];
            rx_trigger_field_reg <= CONTROL_RESET[BIT_TRIG_LO+:2];
        end else begin
            fifo_en_reg          <= fifo_en_next;
            dma_mode_reg         <= dma_mode_next;
            deep_reg             <= deep_next;
            rx_trigger_field_reg <= trig_field_next;
        end
    end

    // ------------------------------------------------------------------
    // tx fifo
    // ------------------------------------------------------------------
    // storage, no reset needed
    always_ff @(posedge ref_clk) begin
        if (tx_push) begin
            tx_mem[tx_wr_ptr_reg] <= reg_wdata[DATA_W-1:0];
        end
    end

    // pointers and count
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_wr_ptr_reg <= '0;
            tx_rd_ptr_reg <= '0;
            tx_count_reg  <= '0;
        end else begin
            tx_wr_ptr_reg <= tx_fifo_clear ? '0 : tx_wr_ptr_reg + PTR_W'(tx_push);
            tx_rd_ptr_reg <= tx_rd_ptr_next;
            tx_count_reg  <= tx_count_next;
        end
    end

    // registered head; bypass when the pushed word becomes head
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_valid <= 1'b0;
            tx_data  <= '0;
        end else begin
            tx_valid <= tx_count_next != '0;
            if (tx_push && tx_wr_ptr_reg == tx_rd_ptr_next) begin
                tx_data <= reg_wdata[DATA_W-1:0];
            end else begin
                tx_data <= tx_mem[tx_rd_ptr_next];
            end
        end
    end

    // ------------------------------------------------------------------
    // rx fifo
    // ------------------------------------------------------------------
    // storage, keeps filling past the trigger until full
    always_ff @(posedge ref_clk) begin
        if (rx_keep) begin
            rx_mem[rx_wr_ptr_reg] <= rx_data;
        end
    end

    // pointers and count
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_wr_ptr_reg <= '0;
            rx_rd_ptr_reg <= '0;
            rx_count_reg  <= '0;
        end else begin
            rx_wr_ptr_reg <= rx_fifo_clear ? '0 : rx_wr_ptr_reg + PTR_W'(rx_keep);
            rx_rd_ptr_reg <= rx_fifo_clear ? '0 : rx_rd_ptr_reg + PTR_W'(rx_take);
            rx_count_reg  <= rx_count_next;
        end
    end

    // ------------------------------------------------------------------
    // dma request pins
    // ------------------------------------------------------------------
    // tx: empty-driven in mode 0, full/empty hysteresis in mode 1
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_dma_request_n <= 1'b0;
        end else if (!dma1_next) begin
            tx_dma_request_n <= tx_count_next != '0;
        end else if (tx_count_next >= cap_next) begin
            tx_dma_request_n <= 1'b1;
        end else if (tx_count_next == '0) begin
            tx_dma_request_n <= 1'b0;
        end
    end

    // rx: data-driven in mode 0, trigger or time-out to empty in mode 1
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_dma_request_n <= 1'b1;
        end else if (!dma1_next) begin
            rx_dma_request_n <= rx_count_next == '0;
        end else if (rx_count_next == '0) begin
            rx_dma_request_n <= 1'b1;
        end else if (rx_count_next >= trig_next || rx_timeout) begin
            rx_dma_request_n <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------------
    // live conditions follow the levels; sticky ones latch events
    always_comb begin
        live_next = '0;
        if (fifo_en_next) begin
            live_next[ST_RX_LEVEL] = rx_count_next >= trig_next;
        end else begin
            live_next[ST_RX_LEVEL] = rx_count_next != '0;
        end
        live_next[ST_TX_LOW] = dma1_next && tx_count_next < trig_next;
        sticky_next = sticky_reg;
        if (reg_write && reg_addr == OFF_CLEAR) begin
            sticky_next = sticky_reg & ~reg_wdata[ST_W-1:0];
        end
        // a set in the clearing cycle wins
        if (rx_keep && rx_count_next == trig_next && fifo_en_next) begin
            sticky_next[ST_RX_HIT] = 1'b1;
        end
        if (rx_timeout) begin
            sticky_next[ST_RX_TIMEOUT] = 1'b1;
        end
        if (rx_overrun) begin
            sticky_next[ST_RX_OVERRUN] = 1'b1;
        end
        sticky_next = sticky_next & STICKY_MASK;
    end

    // sticky bits, enables and the interrupt line
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sticky_reg <= '0;
            enable_reg <= '0;
            irq        <= 1'b0;
        end else begin
            sticky_reg <= sticky_next;
            if (reg_write && reg_addr == OFF_ENABLE) begin
                enable_reg <= reg_wdata[ST_W-1:0];
            end
            irq <= |((sticky_next | live_next) & enable_reg);
        end
    end

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    // data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            unique case (reg_addr)
                OFF_DATA:     reg_rdata <= 8'(rx_mem[rx_rd_ptr_reg]);
                OFF_CONTROL:  reg_rdata <= {rx_trigger_field_reg, deep_reg, 1'b0,
                                            dma_mode_reg, 2'b00, fifo_en_reg};
                OFF_TX_LEVEL: reg_rdata <= 8'(tx_count_reg);
                OFF_RX_LEVEL: reg_rdata <= 8'(rx_count_reg);
                OFF_STATUS:   reg_rdata <= 8'(sticky_reg | live_next);
                OFF_ENABLE:   reg_rdata <= 8'(enable_reg);
                default:      reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic             dma1_now;
    logic [CNT_W-1:0] trig_now;
    assign dma1_now = fifo_en_reg && dma_mode_reg;
    assign trig_now = trig_of(rx_trigger_field_reg, deep_reg);

    AST_TX_MODE0: assert property (!dma1_now |-> tx_dma_request_n == (tx_count_reg != '0))
        else $error("tx request wrong in mode 0");
    AST_RX_MODE0: assert property (!dma1_now |-> rx_dma_request_n == (rx_count_reg == '0))
        else $error("rx request wrong in mode 0");
    AST_TX_MODE1: assert property (dma1_now && tx_count_reg == '0 |-> !tx_dma_request_n)
        else $error("tx request not low on empty fifo in mode 1");
    AST_RX_MODE1_EMPTY: assert property (dma1_now && rx_count_reg == '0 |-> rx_dma_request_n)
        else $error("rx request not high on empty fifo in mode 1");
    AST_RX_ABOVE: assert property (dma1_now && rx_count_reg > trig_now |-> !rx_dma_request_n)
        else $error("rx request high above trigger in mode 1");
    AST_TX_LOW: assert property (reg_read && !reg_write && reg_addr == OFF_STATUS
                                 && dma1_now && tx_count_reg < trig_now |=> reg_rdata[ST_TX_LOW])
        else $error("tx low condition missing");
    AST_RX_HIT: assert property (fifo_en_reg && rx_keep && !rx_take && !ctl_wr
                                 && rx_count_reg == trig_now - 7'h01
                                 |=> sticky_reg[ST_RX_HIT])
        else $error("rx trigger event not flagged");
    AST_TRIG_DEEP: assert property (fifo_en_reg && deep_reg && rx_keep && !rx_take
                                    && !ctl_wr && rx_trigger_field_reg == 2'b11
                                    && rx_count_reg == 7'h37 |=> sticky_reg[ST_RX_HIT])
        else $error("deep trigger level wrong");
    AST_TX_CLEAR: assert property (tx_fifo_clear |=> tx_count_reg == '0 && !tx_valid)
        else $error("tx clear did not empty fifo");
    AST_RX_CLEAR: assert property (rx_fifo_clear |=> rx_count_reg == '0 ##1 1'b1)
        else $error("rx clear did not empty fifo");
    AST_SINGLE: assert property (!fifo_en_reg |-> tx_count_reg <= 7'h01)
        else $error("holding register overfilled");
    AST_RX_WITHDRAW: assert property (fifo_en_reg && rx_count_reg < trig_now
                                      && !$past(enable_reg[ST_TX_LOW])
                                      && (sticky_reg & $past(enable_reg)) == '0 |-> !irq)
        else $error("rx interrupt not withdrawn");
    AST_RESET: assert property (disable iff (1'b0) !rst_n |=> !fifo_en_reg
                                && !dma_mode_reg && !deep_reg && rx_trigger_field_reg == 2'b00)
        else $error("control not cleared by reset");

    COV_MODE1_FULL: cover property (dma1_now && tx_count_reg == CAP_SHALLOW);
    COV_RX_TIMEOUT: cover property (dma1_now && rx_timeout ##1 !rx_dma_request_n);
    COV_CLEAR_BOTH: cover property (tx_fifo_clear && rx_fifo_clear);

endmodule

// ===== test/shifter_model.sv
// shifter stand-in: pops tx characters, delivers rx characters and time-outs
// assumes the bench calls push and timeout between clock edges
`timescale 1ns/1ps

module shifter_model (
    input  wire logic       ref_clk,    // system clock
    input  wire logic [7:0] tx_data,    // head of tx fifo
    input  wire logic       tx_valid,   // tx character available
    input  wire logic       drain,      // bench lets the shifter run
    output logic            tx_pop,     // takes the head
    output logic [7:0]      rx_data,    // delivered character
    output logic            rx_push,    // delivery pulse
    output logic            rx_timeout  // time-out pulse
);
    logic [7:0] got[$];
    initial begin
        {tx_pop, rx_push, rx_timeout, rx_data} = 11'h000;
    end
    // pop every other cycle, so the fifo sees a slow shifter
    always @(posedge ref_clk) begin
        if (tx_pop && tx_valid) got.push_back(tx_data);
        tx_pop <= drain && tx_valid && !tx_pop;
    end
    // released data line shows the inverse of the last character
    task push(input logic [7:0] d);
        @(posedge ref_clk); rx_data <= d; rx_push <= 1'b1;
        @(posedge ref_clk); rx_push <= 1'b0; rx_data <= ~d; #1;
    endtask
    task timeout();
        @(posedge ref_clk); rx_timeout <= 1'b1;
        @(posedge ref_clk); rx_timeout <= 1'b0; #1;
    endtask
endmodule

// ===== test/uart_fifo_control_dma_handshake_tb_top.sv
// bench: queue model of both fifos checked through registers and dma pins
// assumes the fifo control design and the shifter model
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end

module uart_fifo_control_dma_handshake_tb_top;
    import fifo_ctl_pkg::*;
    logic       ref_clk = 0, rst_n = 0, reg_write = 0, reg_read = 0, drain = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, tx_data, rx_data, d, g;
    logic       tx_valid, tx_pop, rx_push, rx_timeout, tx_n, rx_n, irq;
    int         mismatches = 0, samples_checked = 0, rxq[$], txq[$], e, v;
    int         trg[2][4] = '{'{1, 4, 8, 14}, '{1, 16, 32, 56}};

    uart_fifo_control u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .tx_data(tx_data), .tx_valid(tx_valid), .tx_pop(tx_pop),
        .rx_data(rx_data), .rx_push(rx_push), .rx_timeout(rx_timeout),
        .tx_dma_request_n(tx_n), .rx_dma_request_n(rx_n), .irq(irq));
    shifter_model u_shf (.ref_clk(ref_clk), .tx_data(tx_data), .tx_valid(tx_valid),
        .drain(drain), .tx_pop(tx_pop), .rx_data(rx_data), .rx_push(rx_push),
        .rx_timeout(rx_timeout));

    initial forever #50 ref_clk = ~ref_clk;
    // register bus cycles, each settled one step after its edge
    task wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge ref_clk); reg_addr <= a; reg_wdata <= w; reg_write <= 1'b1;
        @(posedge ref_clk); reg_write <= 1'b0; #1;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] r);
        @(posedge ref_clk); reg_addr <= a; reg_read <= 1'b1;
        @(posedge ref_clk); reg_read <= 1'b0; #1; r = reg_rdata;
    endtask
    task push();
        v = $urandom % 256; rxq.push_back(v); u_shf.push(8'(v));
    endtask
    task pop();
        e = rxq.pop_front(); rd(OFF_DATA, d); `CHK(d, 8'(e))
    endtask
    task tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task drain_tx();
        drain <= 1'b1;
        for (int i = 0; i < 300 && tx_valid !== 1'b0; i++) @(posedge ref_clk);
        if (tx_valid !== 1'b0) begin mismatches++; tally_and_finish(); end
        drain <= 1'b0; @(posedge ref_clk); #1;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        tally_and_finish();
    end
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        void'($urandom(28));
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1; #1;
        `CHK({tx_n, rx_n, irq}, 3'b010)
        rd(OFF_CONTROL, d); `CHK(d, CONTROL_RESET)
        rd(8'h05, d); `CHK(d, 8'h00)
        wr(OFF_ENABLE, 8'h05);
        for (int dp = 0; dp < 2; dp++) for (int t = 0; t < 4; t++) begin
            wr(OFF_CONTROL, 8'(8'h0b | (t << 6) | (dp << 5))); rxq.delete();
            repeat (trg[dp][t] - 1) push();
            rd(OFF_STATUS, d); `CHK({d[2:0], rx_n}, 4'b0101)
            push();
            rd(OFF_STATUS, d); `CHK({d[2:0], rx_n, irq}, 5'b11101)
            push(); pop(); `CHK(rx_n, 1'b0)
            pop(); rd(OFF_STATUS, d); `CHK({d[0], rx_n}, {1'b0, rxq.size() == 0})
            rd(OFF_RX_LEVEL, d); `CHK(d, 8'(rxq.size()))
            wr(OFF_CLEAR, 8'h1c); @(posedge ref_clk); #1; `CHK(irq, 1'b0)
        end
        wr(OFF_CONTROL, 8'h4b); rxq.delete();
        rd(OFF_RX_LEVEL, d); `CHK(d, 8'h00)
        rd(OFF_CONTROL, d); `CHK(d, 8'h49)
        push(); `CHK(rx_n, 1'b1)
        u_shf.timeout(); `CHK(rx_n, 1'b0)
        rd(OFF_STATUS, d); `CHK({d[3], irq}, 2'b10)
        wr(OFF_CONTROL, 8'h0f); rxq.delete();
        rd(OFF_STATUS, d); `CHK(d[1], 1'b1)
        for (int i = 0; i < 17; i++) begin
            `CHK(tx_n, i == 16)
            v = $urandom % 256; wr(OFF_DATA, 8'(v)); if (i < 16) txq.push_back(v);
        end
        rd(OFF_TX_LEVEL, d); `CHK(d, 8'h10)
        rd(OFF_STATUS, d); `CHK(d[1], 1'b0)
        drain_tx(); `CHK(tx_n, 1'b0)
        `CHK(u_shf.got.size(), 16)
        while (txq.size() > 0) begin
            e = txq.pop_front(); g = u_shf.got.pop_front(); `CHK(g, 8'(e))
        end
        wr(OFF_DATA, 8'h5a); wr(OFF_DATA, 8'ha5); wr(OFF_CONTROL, 8'h0d);
        rd(OFF_TX_LEVEL, d); `CHK(d, 8'h00)
        rd(OFF_CONTROL, d); `CHK({d, tx_n}, 9'h012)
        wr(OFF_CONTROL, 8'h00); wr(OFF_DATA, 8'h3c); wr(OFF_DATA, 8'hc3);
        rd(OFF_TX_LEVEL, d); `CHK({d, tx_n}, 9'h003)
        rd(OFF_STATUS, d); `CHK(d[1], 1'b0)
        push(); `CHK(rx_n, 1'b0)
        pop(); `CHK(rx_n, 1'b1)
        drain_tx(); `CHK(tx_n, 1'b0)
        tally_and_finish();
    end
endmodule
